// ### dmap_top.sv
// domain/master access permission table with avalon-mm register slave
// What this block does
// - a write-block bit at 0 lets that master's writes pass; 1 refuses them
// - a read-block bit at 0 lets that master's reads pass; 1 refuses them
// - each register holds two domains: upper in bits 29:16, lower in 13:0
// - master n has its read bit at 2n and write bit at 2n+1 in the group
// - domains 8 and 9 live at offset 0xc0, domain 9 upper
// - domains 10 and 11 live at offset 0xc4, domain 11 upper
// - every permission bit clears to 0 at reset, allowing all access except master 7's to domains 6 to 11, which is refused
// - permission bits are read/write; bits 31:30 and 15:14 are reserved
// - domain 7 takes bits 29:16 and domain 6 bits 13:0 of their register
//
// Implementation choice: the Avalon-MM register port.
`include "dmap_consts.svh"

module dmap_top (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic [1:0] o_avs_response,
  output logic o_avs_waitrequest,
  input wire dmap_pkg::dmap_acc_req_t i_acc_req,
  output dmap_pkg::dmap_acc_rsp_t o_acc_rsp
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    dmap_pkg::dmap_perm_t perm;
    dmap_pkg::dmap_bus_st_t bus;
    logic [31:0] rdata;
    logic [1:0] resp;
    dmap_pkg::dmap_acc_rsp_t rsp;
  } dmap_state_t;

  dmap_state_t st_r;
  dmap_state_t st_nxt;
  dmap_pkg::dmap_avs_req_t avs;
  dmap_pkg::dmap_dec_t dec;
  logic chk_block;
  logic chk_in_range;

  assign avs = '{read: i_avs_read, write: i_avs_write, address: i_avs_address,
                 writedata: i_avs_writedata, byteenable: i_avs_byteenable};
  assign dec = dmap_pkg::dmap_addr_dec(avs.address);

  // ----------------------------------------
  // permission lookup
  // ----------------------------------------
  dmap_check u_check (
    .i_perm(st_r.perm),
    .i_req(i_acc_req),
    .o_block(chk_block),
    .o_in_range(chk_in_range)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rsp.valid = i_acc_req.valid;
    // verdict only has meaning while valid; held low otherwise
    st_nxt.rsp.block = i_acc_req.valid && chk_block;
    st_nxt.rsp.in_range = i_acc_req.valid && chk_in_range;
    unique case (st_r.bus)
      dmap_pkg::DMAP_BUS_IDLE:
      begin
        // one wait state: read data is captured here and stands at the release edge
        if (avs.read || avs.write)
        begin
          st_nxt.bus = dmap_pkg::DMAP_BUS_DONE;
          st_nxt.rdata = dec.hit ? st_r.perm[dec.idx] : `DMAP_RDATA_NONE;
          st_nxt.resp = dec.hit ? `DMAP_RSP_OKAY : `DMAP_RSP_DECERR;
        end
      end
      dmap_pkg::DMAP_BUS_DONE:
      begin
        st_nxt.bus = dmap_pkg::DMAP_BUS_IDLE;
        // the write lands at the edge where waitrequest is seen low
        if (avs.write && dec.hit)
        begin
          st_nxt.perm[dec.idx] = (st_r.perm[dec.idx] & ~dmap_pkg::dmap_be_mask(avs.byteenable))
            | (avs.writedata & dmap_pkg::dmap_be_mask(avs.byteenable) & `DMAP_PERM_WMASK);
        end
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      st_r.perm <= {3{`DMAP_PERM_RST}};
      st_r.bus <= dmap_pkg::DMAP_BUS_IDLE;
      st_r.rdata <= `DMAP_RDATA_NONE;
      st_r.resp <= `DMAP_RSP_OKAY;
      st_r.rsp <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_avs_waitrequest = (avs.read || avs.write) && (st_r.bus != dmap_pkg::DMAP_BUS_DONE);
  assign o_avs_readdata = st_r.rdata;
  assign o_avs_response = st_r.resp;
  assign o_acc_rsp = st_r.rsp;

  // ----------------------------------------
  // assertion helpers
  // ----------------------------------------
  logic [1:0] h_ridx;
  logic [4:0] h_bidx;
  logic h_in_win;
  logic h_sel_bit;
  logic bus_done;

  assign h_ridx = dmap_pkg::dmap_reg_idx(i_acc_req.domain);
  assign h_bidx = dmap_pkg::dmap_bit_idx(i_acc_req.domain, i_acc_req.master, i_acc_req.write);
  assign h_in_win = (i_acc_req.domain >= `DMAP_DOM_FIRST) && (i_acc_req.domain <= `DMAP_DOM_LAST)
                    && (i_acc_req.master <= `DMAP_MST_LAST);
  assign h_sel_bit = st_r.perm[h_ridx][h_bidx];
  assign bus_done = (avs.read || avs.write) && !o_avs_waitrequest;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking

  default disable iff (i_sys_rst);

  a_write_blocked: assert property (
    i_acc_req.valid && i_acc_req.write && h_in_win && h_sel_bit
    |=> o_acc_rsp.valid && o_acc_rsp.block)
    else $error("write with block bit set was let through");

  a_write_allowed: assert property (
    i_acc_req.valid && i_acc_req.write && h_in_win && !h_sel_bit
    |=> o_acc_rsp.valid && !o_acc_rsp.block)
    else $error("write with block bit clear was refused");

  a_read_blocked: assert property (
    i_acc_req.valid && !i_acc_req.write && h_in_win && h_sel_bit
    |=> o_acc_rsp.block)
    else $error("read with block bit set was let through");

  a_read_allowed: assert property (
    i_acc_req.valid && !i_acc_req.write && h_in_win && !h_sel_bit
    |=> !o_acc_rsp.block)
    else $error("read with block bit clear was refused");

  a_reserved_zero: assert property (
    (st_r.perm[0] & ~`DMAP_PERM_WMASK) == 32'h0000_0000
    && (st_r.perm[1] & ~`DMAP_PERM_WMASK) == 32'h0000_0000
    && (st_r.perm[2] & ~`DMAP_PERM_WMASK) == 32'h0000_0000)
    else $error("reserved permission bits became set");

  a_group_split: assert property (
    i_acc_req.valid && h_in_win && i_acc_req.domain[0]
    |=> o_acc_rsp.block == $past(st_r.perm[h_ridx][5'h10 + {1'b0, i_acc_req.master, i_acc_req.write}]))
    else $error("upper domain did not use bits 29:16");

  a_bit_position: assert property (
    i_acc_req.valid && h_in_win && !i_acc_req.domain[0]
    |=> o_acc_rsp.block == $past(st_r.perm[h_ridx][{1'b0, i_acc_req.master, i_acc_req.write}]))
    else $error("master bit position is not 2n or 2n+1");

  a_read_d8_9: assert property (
    i_avs_read && bus_done && i_avs_address == `DMAP_OFS_D8_9
    |-> o_avs_readdata == st_r.perm[1] && o_avs_response == `DMAP_RSP_OKAY)
    else $error("0xc0 did not return domains 8 and 9");

  a_read_d10_11: assert property (
    i_avs_read && bus_done && i_avs_address == `DMAP_OFS_D10_11
    |-> o_avs_readdata == st_r.perm[2])
    else $error("0xc4 did not return domains 10 and 11");

  a_read_d6_7: assert property (
    i_avs_read && bus_done && i_avs_address == `DMAP_OFS_D6_7
    |-> o_avs_readdata == st_r.perm[0])
    else $error("domains 6 and 7 register read wrong word");

  a_reset_clear: assert property (
    $past(i_sys_rst) |-> st_r.perm == '0 && !o_acc_rsp.valid)
    else $error("permission table not clear after reset");

  a_write_lands: assert property (
    i_avs_write && bus_done && i_avs_address == `DMAP_OFS_D8_9 && i_avs_byteenable == 4'hf
    |=> st_r.perm[1] == ($past(i_avs_writedata) & `DMAP_PERM_WMASK))
    else $error("full word write to 0xc0 did not land");

  a_d9_master6_wr: assert property (
    i_acc_req.valid && i_acc_req.domain == 4'h9 && i_acc_req.master == 3'h6 && i_acc_req.write
    |=> o_acc_rsp.block == $past(st_r.perm[1][29]))
    else $error("domain 9 master 6 write not on bit 29");

  a_unmapped_decerr: assert property (
    i_avs_read && bus_done && !dec.hit
    |-> o_avs_response == `DMAP_RSP_DECERR && o_avs_readdata == 32'h0000_0000)
    else $error("unmapped read did not give decode error");

  a_wait_bound: assert property (
    (i_avs_read || i_avs_write) |-> ##[0:1] !o_avs_waitrequest)
    else $error("waitrequest held longer than one cycle");

  a_no_write_early: assert property (
    i_avs_write && o_avs_waitrequest |=> st_r.perm == $past(st_r.perm))
    else $error("write took effect before waitrequest fell");

  // ----------------------------------------
  // covers
  // ----------------------------------------
  c_write_blocked: cover property (
    i_acc_req.valid && i_acc_req.write && h_in_win ##1 o_acc_rsp.block);

  c_read_blocked: cover property (
    i_acc_req.valid && !i_acc_req.write && h_in_win ##1 o_acc_rsp.block);

  c_reg_write_then_block: cover property (
    i_avs_write && bus_done ##[1:8] o_acc_rsp.valid && o_acc_rsp.block);

  c_unmapped_access: cover property (
    (i_avs_read || i_avs_write) && bus_done && !dec.hit);

  c_back_to_back: cover property (
    bus_done ##1 (i_avs_read || i_avs_write) ##1 bus_done);

endmodule

// ### dmap_consts.svh
// offsets, field positions, reset values and codes of the domain access permission table
`ifndef DMAP_CONSTS_SVH
`define DMAP_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DMAP_OFS_D6_7 8'hbc
`define DMAP_OFS_D8_9 8'hc0
`define DMAP_OFS_D10_11 8'hc4

// ----------------------------------------
// register indices inside the table
// ----------------------------------------
`define DMAP_IDX_D6_7 2'h0
`define DMAP_IDX_D8_9 2'h1
`define DMAP_IDX_D10_11 2'h2

// ----------------------------------------
// field layout and reset
// ----------------------------------------
`define DMAP_PERM_RST 32'h0000_0000
`define DMAP_PERM_WMASK 32'h3fff_3fff
`define DMAP_UPPER_BASE 5'h10
`define DMAP_LOWER_BASE 5'h00
`define DMAP_DOM_FIRST 4'h6
`define DMAP_DOM_LAST 4'hb
`define DMAP_MST_LAST 3'h6

// ----------------------------------------
// bus answer codes
// ----------------------------------------
`define DMAP_RSP_OKAY 2'h0
`define DMAP_RSP_DECERR 2'h3
`define DMAP_RDATA_NONE 32'h0000_0000

`endif

// ### dmap_pkg.sv
// types and shared decode functions of the domain access permission table
`include "dmap_consts.svh"

package dmap_pkg;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef logic [2:0][31:0] dmap_perm_t;

  typedef struct packed {
    logic valid;
    logic [3:0] domain;
    logic [2:0] master;
    logic write;
  } dmap_acc_req_t;

  typedef struct packed {
    logic valid;
    logic block;
    logic in_range;
  } dmap_acc_rsp_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } dmap_avs_req_t;

  typedef struct packed {
    logic hit;
    logic [1:0] idx;
  } dmap_dec_t;

  typedef enum logic {DMAP_BUS_IDLE, DMAP_BUS_DONE} dmap_bus_st_t;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic dmap_dec_t dmap_addr_dec(input logic [7:0] addr);
    dmap_dec_t d;
    d.hit = 1'b1;
    d.idx = `DMAP_IDX_D6_7;
    unique case (addr)
      `DMAP_OFS_D6_7: d.idx = `DMAP_IDX_D6_7;
      `DMAP_OFS_D8_9: d.idx = `DMAP_IDX_D8_9;
      `DMAP_OFS_D10_11: d.idx = `DMAP_IDX_D10_11;
      default: d.hit = 1'b0;
    endcase
    return d;
  endfunction

  // two domains per word: the odd one sits in the upper group
  function automatic logic [1:0] dmap_reg_idx(input logic [3:0] dom);
    logic [3:0] rel;
    rel = dom - `DMAP_DOM_FIRST;
    return rel[2:1];
  endfunction

  function automatic logic [4:0] dmap_bit_idx(input logic [3:0] dom, input logic [2:0] mst,
                                              input logic wr);
    logic [4:0] base;
    base = dom[0] ? `DMAP_UPPER_BASE : `DMAP_LOWER_BASE;
    return base + {1'b0, mst, wr};
  endfunction

  function automatic logic [31:0] dmap_be_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

endpackage

// ### dmap_check.sv
// permission lookup for one translated access
`include "dmap_consts.svh"

module dmap_check (
  input wire dmap_pkg::dmap_perm_t i_perm,
  input wire dmap_pkg::dmap_acc_req_t i_req,
  output logic o_block,
  output logic o_in_range
);

  logic dom_ok;
  logic mst_ok;
  logic [1:0] ridx;
  logic [4:0] bidx;

  always_comb
  begin
    dom_ok = (i_req.domain >= `DMAP_DOM_FIRST) && (i_req.domain <= `DMAP_DOM_LAST);
    mst_ok = i_req.master <= `DMAP_MST_LAST;
    ridx = dmap_pkg::dmap_reg_idx(i_req.domain);
    bidx = dmap_pkg::dmap_bit_idx(i_req.domain, i_req.master, i_req.write);
    o_in_range = dom_ok && mst_ok;
    // domains outside this table are judged elsewhere; an unknown master is refused
    o_block = 1'b0;
    if (dom_ok)
    begin
      o_block = mst_ok ? i_perm[ridx][bidx] : 1'b1;
    end
  end

endmodule

// ### dmap_mst_model.sv
// bus-master model that issues translated accesses for the permission check
module dmap_mst_model (
  input wire logic i_core_clk,
  input wire logic i_go,
  input wire logic [3:0] i_dom,
  input wire logic [2:0] i_mst,
  input wire logic i_wr,
  output dmap_pkg::dmap_acc_req_t o_acc_req
);
  logic [3:0] junk_r = 4'h9;

  // idle cycles show a changing pattern so a stale domain is never mistaken for a live one
  always @(posedge i_core_clk)
  begin
    junk_r <= junk_r + 4'h5;
    if (i_go)
      o_acc_req <= {1'b1, i_dom, i_mst, i_wr};
    else
      o_acc_req <= {1'b0, junk_r, junk_r[2:0], junk_r[3]};
  end
endmodule

// ### tb_domain_master_access_permission.sv
// self-checking bench for the domain/master access permission table
`include "dmap_consts.svh"

module tb_domain_master_access_permission;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic sys_rst, avs_read, avs_write, avs_waitrequest, go, wr;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdata;
  logic [3:0] avs_byteenable, dom;
  logic [2:0] mst;
  logic [1:0] avs_response, resp;
  dmap_pkg::dmap_acc_req_t acc_req;
  dmap_pkg::dmap_acc_rsp_t acc_rsp;
  int num_errors = 0;
  int cmp_count = 0;

  always #5 core_clk = ~core_clk;

  dmap_top dut (.i_core_clk(core_clk), .i_sys_rst(sys_rst), .i_avs_address(avs_address),
    .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
    .i_avs_byteenable(avs_byteenable), .o_avs_readdata(avs_readdata), .o_avs_response(avs_response),
    .o_avs_waitrequest(avs_waitrequest), .i_acc_req(acc_req), .o_acc_rsp(acc_rsp));

  dmap_mst_model u_mst (.i_core_clk(core_clk), .i_go(go), .i_dom(dom), .i_mst(mst), .i_wr(wr),
    .o_acc_req(acc_req));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // read data and response are taken at the same edge at which waitrequest is seen low
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    @(posedge core_clk);
    avs_read <= rd;
    avs_write <= !rd;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    for (n = 0; n < 20; n++)
    begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0)
      begin
        rdata = avs_readdata;
        resp = avs_response;
        break;
      end
    end
    if (n == 20)
    begin
      num_errors++;
      give_verdict();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
    bus(1'b1, a, 32'h0000_0000, 4'hf);
    check(rdata, exp);
    check({30'h0, resp}, {30'h0, exp_resp});
  endtask

  task automatic acc(input logic [3:0] d, input logic [2:0] m, input logic w, input logic eb,
                     input logic er);
    @(posedge core_clk);
    go <= 1'b1;
    dom <= d;
    mst <= m;
    wr <= w;
    @(posedge core_clk);
    go <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
    check({29'h0, acc_rsp.valid, acc_rsp.block, acc_rsp.in_range}, {29'h0, 1'b1, eb, er});
  endtask

  function automatic logic [7:0] ofs(input int d);
    if (d < 8)
      return `DMAP_OFS_D6_7;
    return (d < 10) ? `DMAP_OFS_D8_9 : `DMAP_OFS_D10_11;
  endfunction

  task automatic do_reset();
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_vals();
    for (int d = 6; d <= 10; d += 2)
      rd(ofs(d), 32'h0000_0000, 2'h0);
    acc(4'hb, 3'h6, 1'b1, 1'b0, 1'b1);
  endtask

  task automatic t_rw_mask();
    for (int d = 6; d <= 10; d += 2)
    begin
      bus(1'b0, ofs(d), 32'hffff_ffff, 4'hf);
      rd(ofs(d), 32'h3fff_3fff, 2'h0);
    end
    bus(1'b0, 8'hc0, 32'h0000_0000, 4'h1);
    rd(8'hc0, 32'h3fff_3f00, 2'h0);
  endtask

  task automatic t_unmapped();
    bus(1'b0, 8'hc8, 32'h0000_0000, 4'hf);
    rd(8'hc8, 32'h0000_0000, 2'h3);
    rd(8'hc4, 32'h3fff_3fff, 2'h0);
  endtask

  task automatic t_bits();
    int pos;
    int e;
    for (int d = 6; d <= 11; d++)
      for (int m = 0; m <= 6; m++)
        for (int w = 0; w <= 1; w++)
        begin
          pos = (d % 2) * 16 + 2 * m + w;
          e = d ^ 1;
          bus(1'b0, ofs(d), 32'h1 << pos, 4'hf);
          rd(ofs(d), 32'h1 << pos, 2'h0);
          acc(d[3:0], m[2:0], w[0], 1'b1, 1'b1);
          acc(d[3:0], m[2:0], !w[0], 1'b0, 1'b1);
          acc(e[3:0], m[2:0], w[0], 1'b0, 1'b1);
        end
  endtask

  task automatic t_range();
    acc(4'h5, 3'h0, 1'b1, 1'b0, 1'b0);
    acc(4'hc, 3'h2, 1'b0, 1'b0, 1'b0);
    acc(4'h6, 3'h7, 1'b0, 1'b1, 1'b0);
  endtask

  // a second reset in mid-run must bring back full access
  task automatic t_mid_reset();
    bus(1'b0, 8'hc4, 32'hffff_ffff, 4'hf);
    do_reset();
    rd(8'hc4, 32'h0000_0000, 2'h0);
    acc(4'hb, 3'h6, 1'b1, 1'b0, 1'b1);
  endtask

  initial
  begin
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
    go = 1'b0;
    dom = 4'h0;
    mst = 3'h0;
    wr = 1'b0;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset_vals();
    t_rw_mask();
    t_unmapped();
    t_bits();
    t_range();
    t_mid_reset();
    give_verdict();
  end
endmodule
